//--- include/fwsr_pkg.sv
// package of constants for the flash write-status polling controller
package fwsr_pkg;
    localparam int CLK_PERIOD_NS = 25;
    // read access, write pulse and recovery times of the flash, in ns
    localparam int T_ACC_NS = 100;
    localparam int T_WP_NS = 35;
    localparam int T_REC_NS = 25;
    function automatic int fwsr_ceil_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : fwsr_ceil_cyc
    localparam logic [3:0] ACC_CYC = 4'(fwsr_ceil_cyc(T_ACC_NS));
    localparam logic [3:0] WP_CYC = 4'(fwsr_ceil_cyc(T_WP_NS));
    localparam logic [3:0] REC_CYC = 4'(fwsr_ceil_cyc(T_REC_NS));
    localparam int FL_AW = 19;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_ADDR = 8'h08;
    localparam logic [7:0] OFS_DATA = 8'h0C;
    localparam logic [7:0] OFS_RDATA = 8'h10;
    // control fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_ABORT_BIT = 1;
    localparam int CTRL_OP_LSB = 2;
    // status fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_PASS_BIT = 1;
    localparam int STAT_FAIL_BIT = 2;
    localparam int STAT_READY_BIT = 3;
    localparam int STAT_SECT_BIT = 4;
    // flash status bit positions
    localparam int POLL_BIT = 7;
    localparam int TOGA_BIT = 6;
    localparam int TOUT_BIT = 5;
    localparam int TOGB_BIT = 2;
    localparam logic [7:0] RESET_CMD = 8'hF0;
    localparam logic [FL_AW-1:0] ADDR_RST = '0;
    localparam logic [7:0] DATA_RST = 8'h00;
    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_DPOLL,
        OP_TPOLL
    } fwsr_op_t;
endpackage : fwsr_pkg

//--- verilog/fwsr_cycle.sv
// one asynchronous flash bus cycle, read or write, timed in clock cycles
`timescale 1ns/1ps
module fwsr_cycle
    import fwsr_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic start_in,
    input wire logic we_in,
    input wire logic [FL_AW-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic done_out,
    output logic [7:0] rdata_out,
    output logic ce_n_out,
    output logic oe_n_out,
    output logic we_n_out,
    output logic [FL_AW-1:0] addr_out,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe_out
);
    typedef enum logic [1:0] {C_IDLE, C_SET, C_ACT, C_REC} fwsr_cst_t;
    fwsr_cst_t st_ff, nxt_st;
    logic [3:0] cnt_ff, nxt_cnt;
    logic we_ff, nxt_we;
    logic [FL_AW-1:0] addr_ff, nxt_addr;
    logic [7:0] wd_ff, nxt_wd, rd_ff, nxt_rd;

    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_we = we_ff;
        nxt_addr = addr_ff;
        nxt_wd = wd_ff;
        nxt_rd = rd_ff;
        case (st_ff)
            C_IDLE: begin
                if (start_in) begin
                    nxt_we = we_in;
                    nxt_addr = addr_in;
                    nxt_wd = wdata_in;
                    nxt_st = C_SET;
                end
            end
            C_SET: begin
                nxt_cnt = we_ff ? WP_CYC : ACC_CYC;
                nxt_st = C_ACT;
            end
            C_ACT: begin
                nxt_cnt = cnt_ff - 4'h1;
                if (cnt_ff == 4'h1) begin
                    if (!we_ff) begin
                        nxt_rd = dq_in;
                    end
                    nxt_cnt = REC_CYC;
                    nxt_st = C_REC;
                end
            end
            C_REC: begin
                nxt_cnt = cnt_ff - 4'h1;
                if (cnt_ff == 4'h1) begin
                    nxt_st = C_IDLE;
                end
            end
            default: nxt_st = C_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st_ff <= C_IDLE;
            cnt_ff <= 4'h0;
            we_ff <= 1'b0;
            addr_ff <= ADDR_RST;
            wd_ff <= DATA_RST;
            rd_ff <= DATA_RST;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            we_ff <= nxt_we;
            addr_ff <= nxt_addr;
            wd_ff <= nxt_wd;
            rd_ff <= nxt_rd;
        end
    end

    // strobes end at the close of the active phase, so each read is one strobe
    assign done_out = (st_ff == C_REC) && (cnt_ff == 4'h1);
    assign rdata_out = rd_ff;
    assign ce_n_out = !(st_ff == C_SET || st_ff == C_ACT);
    assign oe_n_out = !(st_ff == C_ACT && !we_ff);
    assign we_n_out = !(st_ff == C_ACT && we_ff);
    assign addr_out = addr_ff;
    assign dq_out = wd_ff;
    assign dq_oe_out = we_ff && (st_ff == C_SET || st_ff == C_ACT);

    property p_wp_len;
        @(posedge clk_in) disable iff (srst_in)
        $fell(we_n_out) |-> !we_n_out [*2] ##1 we_n_out;
    endproperty
    a_wp_len: assert property (p_wp_len) else $error("write pulse length wrong");
endmodule : fwsr_cycle

//--- verilog/fwsr_ctrl.sv
// host-side flash status polling controller with apb registers
// Functional notes
// - host polls at the programmed address to get valid polling status.
// - host polls erase status at an address inside a chosen sector.
// - host takes valid data only from the read after the true value.
// - host rechecks the polling bit after seeing timeout fail set.
// - host reads twice, compares toggle bit; no change means done.
// - still toggling with timeout set and after recheck: fail, send reset.
// - still toggling with timeout clear: restart from the first double read.
// - reset command is one write of F0 at any address.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module fwsr_ctrl
    import fwsr_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic FL_CE_N_OUT,
    output logic FL_OE_N_OUT,
    output logic FL_WE_N_OUT,
    output logic [FL_AW-1:0] FL_ADDR_OUT,
    input wire logic [7:0] FL_DQ_IN,
    output logic [7:0] FL_DQ_OUT,
    output logic FL_DQ_OE_OUT,
    input wire logic FL_READY_BUSY_N_IN
);
    typedef enum logic [2:0] {S_IDLE, S_RD_A, S_RD_B, S_RD_C, S_RD_D, S_FIN, S_WR, S_RST}
        fwsr_st_t;
    fwsr_st_t st_ff, nxt_st;
    fwsr_op_t op_ff, nxt_op;
    logic issued_ff, nxt_issued;
    logic pass_ff, nxt_pass, fail_ff, nxt_fail, sect_ff, nxt_sect;
    logic [7:0] first_ff, nxt_first, rdata_ff, nxt_rdata, data_ff, nxt_data;
    logic [FL_AW-1:0] addr_ff, nxt_addr;
    logic ready_ff;
    logic cyc_start, cyc_we, cyc_done;
    logic [7:0] cyc_wdata, cyc_rdata;
    logic acc, wr, start_req, abort_req, mapped;
    logic poll_match, tog_same;

    assign acc = PSEL_IN && PENABLE_IN;
    assign wr = acc && PWRITE_IN;
    assign start_req = wr && (PADDR_IN == OFS_CTRL) && PWDATA_IN[CTRL_START_BIT];
    assign abort_req = wr && (PADDR_IN == OFS_CTRL) && PWDATA_IN[CTRL_ABORT_BIT];
    assign mapped = (PADDR_IN == OFS_CTRL) || (PADDR_IN == OFS_STAT) ||
                    (PADDR_IN == OFS_ADDR) || (PADDR_IN == OFS_DATA) ||
                    (PADDR_IN == OFS_RDATA);
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = acc && !mapped;

    always_comb begin
        case (PADDR_IN)
            OFS_STAT: PRDATA_OUT = {27'h0, sect_ff, ready_ff, fail_ff, pass_ff,
                                    (st_ff != S_IDLE) || issued_ff};
            OFS_ADDR: PRDATA_OUT = {{(32 - FL_AW){1'b0}}, addr_ff};
            OFS_DATA: PRDATA_OUT = {24'h0, data_ff};
            OFS_RDATA: PRDATA_OUT = {24'h0, rdata_ff};
            default: PRDATA_OUT = 32'h0;
        endcase
    end

    // pass when the polling bit already shows the datum being programmed
    assign poll_match = cyc_rdata[POLL_BIT] == data_ff[POLL_BIT];
    assign tog_same = cyc_rdata[TOGA_BIT] == first_ff[TOGA_BIT];
    assign cyc_start = !issued_ff && st_ff != S_IDLE && !abort_req;
    assign cyc_we = (st_ff == S_WR) || (st_ff == S_RST);
    assign cyc_wdata = (st_ff == S_RST) ? RESET_CMD : data_ff;

    always_comb begin
        nxt_st = st_ff;
        nxt_op = op_ff;
        nxt_issued = issued_ff;
        nxt_pass = pass_ff;
        nxt_fail = fail_ff;
        nxt_sect = sect_ff;
        nxt_first = first_ff;
        nxt_rdata = rdata_ff;
        nxt_data = data_ff;
        nxt_addr = addr_ff;
        if (wr && PADDR_IN == OFS_ADDR && st_ff == S_IDLE) begin
            nxt_addr = PWDATA_IN[FL_AW-1:0];
        end
        if (wr && PADDR_IN == OFS_DATA && st_ff == S_IDLE) begin
            nxt_data = PWDATA_IN[7:0];
        end
        if (cyc_start) begin
            nxt_issued = 1'b1;
        end
        if (cyc_done) begin
            nxt_issued = 1'b0;
        end
        if (abort_req) begin
            // an in-flight strobe still finishes; issued stays set until its done
            nxt_st = S_IDLE;
        end else begin
            case (st_ff)
                S_IDLE: begin
                    if (start_req && !issued_ff) begin
                        nxt_op = fwsr_op_t'(PWDATA_IN[CTRL_OP_LSB +: 2]);
                        nxt_pass = 1'b0;
                        nxt_fail = 1'b0;
                        nxt_sect = 1'b0;
                        case (fwsr_op_t'(PWDATA_IN[CTRL_OP_LSB +: 2]))
                            OP_READ: nxt_st = S_FIN;
                            OP_WRITE: nxt_st = S_WR;
                            default: nxt_st = S_RD_A;
                        endcase
                    end
                end
                S_RD_A: begin
                    if (cyc_done) begin
                        nxt_first = cyc_rdata;
                        if (op_ff == OP_TPOLL) begin
                            nxt_st = S_RD_B;
                        end else if (poll_match) begin
                            nxt_st = S_FIN;
                        end else if (cyc_rdata[TOUT_BIT]) begin
                            nxt_st = S_RD_B;
                        end
                    end
                end
                S_RD_B: begin
                    if (cyc_done) begin
                        if (op_ff == OP_DPOLL) begin
                            nxt_st = poll_match ? S_FIN : S_RST;
                        end else begin
                            nxt_sect = cyc_rdata[TOGB_BIT] != first_ff[TOGB_BIT];
                            if (tog_same) begin
                                nxt_st = S_FIN;
                            end else if (cyc_rdata[TOUT_BIT]) begin
                                nxt_st = S_RD_C;
                            end else begin
                                nxt_st = S_RD_A;
                            end
                        end
                    end
                end
                S_RD_C: begin
                    if (cyc_done) begin
                        nxt_first = cyc_rdata;
                        nxt_st = S_RD_D;
                    end
                end
                S_RD_D: begin
                    if (cyc_done) begin
                        nxt_st = tog_same ? S_FIN : S_RST;
                    end
                end
                S_FIN: begin
                    if (cyc_done) begin
                        nxt_rdata = cyc_rdata;
                        nxt_pass = 1'b1;
                        nxt_st = S_IDLE;
                    end
                end
                S_WR: begin
                    if (cyc_done) begin
                        nxt_pass = 1'b1;
                        nxt_st = S_IDLE;
                    end
                end
                S_RST: begin
                    if (cyc_done) begin
                        nxt_fail = 1'b1;
                        nxt_st = S_IDLE;
                    end
                end
                default: nxt_st = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            st_ff <= S_IDLE;
            op_ff <= OP_READ;
            issued_ff <= 1'b0;
            pass_ff <= 1'b0;
            fail_ff <= 1'b0;
            sect_ff <= 1'b0;
            first_ff <= DATA_RST;
            rdata_ff <= DATA_RST;
            data_ff <= DATA_RST;
            addr_ff <= ADDR_RST;
            ready_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            op_ff <= nxt_op;
            issued_ff <= nxt_issued;
            pass_ff <= nxt_pass;
            fail_ff <= nxt_fail;
            sect_ff <= nxt_sect;
            first_ff <= nxt_first;
            rdata_ff <= nxt_rdata;
            data_ff <= nxt_data;
            addr_ff <= nxt_addr;
            ready_ff <= FL_READY_BUSY_N_IN;
        end
    end

    fwsr_cycle u_cycle (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .start_in(cyc_start),
        .we_in(cyc_we),
        .addr_in(addr_ff),
        .wdata_in(cyc_wdata),
        .done_out(cyc_done),
        .rdata_out(cyc_rdata),
        .ce_n_out(FL_CE_N_OUT),
        .oe_n_out(FL_OE_N_OUT),
        .we_n_out(FL_WE_N_OUT),
        .addr_out(FL_ADDR_OUT),
        .dq_in(FL_DQ_IN),
        .dq_out(FL_DQ_OUT),
        .dq_oe_out(FL_DQ_OE_OUT)
    );

    property p_poll_addr;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (cyc_start && st_ff inside {S_RD_A, S_RD_B}) |-> ##1 !FL_CE_N_OUT && FL_ADDR_OUT == addr_ff;
    endproperty
    a_poll_addr: assert property (p_poll_addr) else $error("poll read at wrong address");
    property p_erase_addr;
        @(posedge CLK_IN) disable iff (SRST_IN)
        $fell(FL_OE_N_OUT) |-> FL_ADDR_OUT == addr_ff;
    endproperty
    a_erase_addr: assert property (p_erase_addr) else $error("status read address moved");
    property p_extra_read;
        @(posedge CLK_IN) disable iff (SRST_IN)
        $rose(pass_ff) && op_ff != OP_WRITE |-> $past(st_ff) == S_FIN;
    endproperty
    a_extra_read: assert property (p_extra_read) else $error("pass without data read");
    property p_recheck;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (st_ff == S_RD_A && op_ff == OP_DPOLL && cyc_done && !poll_match && cyc_rdata[TOUT_BIT])
        |=> st_ff == S_RD_B;
    endproperty
    a_recheck: assert property (p_recheck) else $error("no recheck after timeout");
    property p_double_read;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (st_ff == S_RD_A && op_ff == OP_TPOLL && cyc_done && !abort_req) |=> st_ff == S_RD_B;
    endproperty
    a_double_read: assert property (p_double_read) else $error("single toggle read");
    property p_fail_reset;
        @(posedge CLK_IN) disable iff (SRST_IN)
        $rose(fail_ff) |-> $past(st_ff) == S_RST && $past(cyc_done);
    endproperty
    a_fail_reset: assert property (p_fail_reset) else $error("fail without reset");
    property p_restart;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (st_ff == S_RD_B && op_ff == OP_TPOLL && cyc_done && !tog_same
         && !cyc_rdata[TOUT_BIT] && !abort_req) |=> st_ff == S_RD_A;
    endproperty
    a_restart: assert property (p_restart) else $error("toggle loop not restarted");
    property p_reset_cmd;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (st_ff == S_RST && cyc_start) |-> ##2 !FL_WE_N_OUT && FL_DQ_OE_OUT && FL_DQ_OUT == RESET_CMD;
    endproperty
    a_reset_cmd: assert property (p_reset_cmd) else $error("reset command not F0");
endmodule : fwsr_ctrl

//--- dv/fwsr_flash_model.sv
// behavioural flash device answering the controller's bus cycles with write status
`timescale 1ns/1ps
module fwsr_flash_model
    import fwsr_pkg::*;
(
    input wire logic ce_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic [FL_AW-1:0] addr_in,
    input wire logic [7:0] dq_in,
    input wire logic dq_oe_in,
    output logic [7:0] dq_out,
    output logic ready_busy_n_out
);
    logic [7:0] mem [16];
    int busy_left;
    int arm_reads;
    logic erasing;
    logic stuck;
    logic prot;
    logic tog_a;
    logic tog_b;
    logic [7:0] pdata;
    logic [3:0] pa;
    logic [6:0] erase_sect;
    logic [7:0] val;
    logic busy;
    logic in_sect;
    // two-state strobes: the unknown-to-low step at reset must not look like a cycle end
    bit rd_act;
    bit wr_act;
    initial begin
        busy_left = 0;
        arm_reads = 3;
        erasing = 1'b0;
        stuck = 1'b0;
        prot = 1'b0;
        tog_a = 1'b0;
        tog_b = 1'b0;
        pdata = 8'h00;
        pa = 4'h0;
        erase_sect = 7'h00;
        foreach (mem[i]) mem[i] = 8'h00;
    end
    assign busy = (busy_left > 0);
    assign in_sect = erasing && (addr_in[18:12] == erase_sect);
    assign rd_act = !ce_n_in && !oe_n_in && we_n_in;
    assign wr_act = !ce_n_in && !we_n_in && dq_oe_in;
    // status byte while an algorithm runs, array data otherwise
    always_comb begin
        if (busy) begin
            val = {erasing ? 1'b0 : ~pdata[7], tog_a, stuck, 2'b00, in_sect & tog_b, 2'b00};
        end else begin
            val = mem[addr_in[3:0]];
        end
    end
    // released bus shows the inverse so stale data never reads as valid
    assign dq_out = rd_act ? val : ~val;
    assign ready_busy_n_out = ~busy;
    always @(negedge rd_act) begin
        if (busy) begin
            tog_a <= ~tog_a;
            if (in_sect) begin
                tog_b <= ~tog_b;
            end
            if (!stuck) begin
                busy_left <= busy_left - 1;
                // an erase ends with its last status read; later programs poll normally
                if (busy_left == 1) begin
                    erasing <= 1'b0;
                end
                if (busy_left == 1 && !prot) begin
                    if (erasing) begin
                        foreach (mem[i]) mem[i] <= 8'hFF;
                    end else begin
                        mem[pa] <= pdata;
                    end
                end
            end
        end
    end
    // status starts after the rising edge of the write strobe
    always @(negedge wr_act) begin
        if (dq_in == RESET_CMD) begin
            busy_left <= 0;
            stuck <= 1'b0;
            erasing <= 1'b0;
        end else begin
            pdata <= dq_in;
            pa <= addr_in[3:0];
            busy_left <= arm_reads;
        end
    end
endmodule : fwsr_flash_model

//--- dv/fwsr_ctrl_tb.sv
// self-checking testbench of the flash status polling controller
`timescale 1ns/1ps
module fwsr_ctrl_tb;
    import fwsr_pkg::*;
    logic clk, srst, psel, penable, pwrite, pready, pslverr, ce_n, oe_n, we_n, dq_oe, rb_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, st, rd;
    logic [FL_AW-1:0] fl_addr;
    logic [7:0] dq_host, dq_dev;
    logic last_err;
    int mismatches, checks_done;
    fwsr_ctrl u_dut (.CLK_IN(clk), .SRST_IN(srst), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .FL_CE_N_OUT(ce_n), .FL_OE_N_OUT(oe_n),
        .FL_WE_N_OUT(we_n), .FL_ADDR_OUT(fl_addr), .FL_DQ_IN(dq_dev), .FL_DQ_OUT(dq_host),
        .FL_DQ_OE_OUT(dq_oe), .FL_READY_BUSY_N_IN(rb_n));
    fwsr_flash_model u_flash (.ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
        .addr_in(fl_addr), .dq_in(dq_host), .dq_oe_in(dq_oe), .dq_out(dq_dev),
        .ready_busy_n_out(rb_n));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // one controller operation, waits until the status leaves busy
    task automatic run_op(input logic [1:0] op, input logic [18:0] a, input logic [7:0] d);
        apb(1'b1, OFS_ADDR, {13'h0, a});
        apb(1'b1, OFS_DATA, {24'h0, d});
        apb(1'b1, OFS_CTRL, {28'h0, op, 2'b01});
        do begin
            apb(1'b0, OFS_STAT, 32'h0);
        end while (rd[STAT_BUSY_BIT] !== 1'b0);
        st = rd;
    endtask : run_op
    task automatic t_regs;
        apb(1'b0, OFS_STAT, 32'h0);
        chk(rd, 32'h8);
        apb(1'b0, 8'h20, 32'h0);
        chk({rd[30:0], last_err}, 32'h1);
    endtask : t_regs
    task automatic t_read;
        u_flash.mem[5] = 8'hA5;
        run_op(2'd0, 19'h5, 8'h00);
        chk(32'(st[STAT_PASS_BIT]), 32'h1);
        apb(1'b0, OFS_RDATA, 32'h0);
        chk(rd, 32'hA5);
    endtask : t_read
    task automatic t_program;
        run_op(2'd1, 19'h6, 8'h3C);
        apb(1'b0, OFS_STAT, 32'h0);
        chk(32'(rd[STAT_READY_BIT]), 32'h0);
        run_op(2'd2, 19'h6, 8'h3C);
        chk(st[2:0], 32'h2);
        apb(1'b0, OFS_RDATA, 32'h0);
        chk(rd, 32'h3C);
        apb(1'b0, OFS_STAT, 32'h0);
        chk(32'(rd[STAT_READY_BIT]), 32'h1);
    endtask : t_program
    task automatic t_erase;
        u_flash.erasing = 1'b1;
        u_flash.erase_sect = 7'h00;
        u_flash.busy_left = 4;
        run_op(2'd3, 19'h2, 8'hFF);
        chk(st[2:0], 32'h2);
        apb(1'b0, OFS_RDATA, 32'h0);
        chk(rd, 32'hFF);
    endtask : t_erase
    // a stuck algorithm with the fail bit set ends in a reset command
    task automatic t_fail;
        for (int op = 2; op < 4; op++) begin
            run_op(2'd1, 19'h7, 8'h11);
            u_flash.stuck = 1'b1;
            run_op(2'(op), 19'h7, 8'h11);
            chk(st[2:0], 32'h4);
            chk(32'(u_flash.busy_left), 32'h0);
            chk(32'(u_flash.stuck), 32'h0);
        end
    endtask : t_fail
    // abort a poll that cannot finish, then a plain read must still work
    task automatic t_abort;
        u_flash.mem[5] = 8'h5A;
        u_flash.busy_left = 50;
        apb(1'b1, OFS_DATA, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h9);
        apb(1'b1, OFS_CTRL, 32'h2);
        u_flash.busy_left = 0;
        run_op(2'd0, 19'h5, 8'h00);
        chk(st[2:0], 32'h2);
        apb(1'b0, OFS_RDATA, 32'h0);
        chk(rd, 32'h5A);
    endtask : t_abort
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        summarize();
    end
    initial begin
        mismatches = 0;
        checks_done = 0;
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_read();
        t_program();
        t_erase();
        t_fail();
        t_abort();
        summarize();
    end
endmodule : fwsr_ctrl_tb
